// *** ctd_cfg.svh ***
/*
  constants for the converter trim and dither register bank.
  assumes an included-once header; byte registers behind a plain strobe port.
*/
`ifndef CTD_CFG_SVH
`define CTD_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CTD_ADDR_W          12
`define CTD_OFS_TRIM_A      12'h07E
`define CTD_OFS_TRIM_B      12'h07F
`define CTD_OFS_DITHER      12'h09D
`define CTD_OFS_B0_PH0      12'h102
`define CTD_OFS_B0_PH90     12'h103
`define CTD_OFS_B1_PH0      12'h112
`define CTD_OFS_B1_PH90     12'h113

// ----------------------------------------
// fields and resets
// ----------------------------------------
`define CTD_DITH_EN_BIT     0
`define CTD_DITH_AMP_BIT    1
`define CTD_DITH_ERR_BIT    2
`define CTD_DITH_RSV_HI     7
`define CTD_DITH_RSV_LO     3
`define CTD_RST_DITHER      8'h01
`define CTD_RST_TRIM        8'h00
`define CTD_READ_UNMAPPED   8'h00

// ----------------------------------------
// fuse load
// ----------------------------------------
`define CTD_NUM_FUSE        7
`define CTD_FUSE_IDX_W      3
`define CTD_FUSE_LAST       3'h6

`endif

// *** ctd_fuse_loader.sv ***
/*
  sequences the factory fuse values into the register bank after reset.
  assumes fuse values are static levels from the same clock domain.
*/
`timescale 1ns/1ps
`include "ctd_cfg.svh"

module ctd_fuse_loader (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  output logic                              loadValid,
  output logic [`CTD_FUSE_IDX_W-1:0]        loadIndex,
  output logic                              loadDone
);

  // ----------------------------------------
  // one entry per cycle; a host write to an entry not yet loaded is overwritten when the load reaches it
  // ----------------------------------------
  ctd_pkg::ctd_load_state_type state;
  ctd_pkg::ctd_load_state_type next_state;
  logic [`CTD_FUSE_IDX_W-1:0]  next_loadIndex;

  always_comb begin
    next_state     = state;
    next_loadIndex = loadIndex;
    case (state)
      ctd_pkg::CTD_LOAD_IDLE: begin
        next_state     = ctd_pkg::CTD_LOAD_RUN;
        next_loadIndex = '0;
      end
      ctd_pkg::CTD_LOAD_RUN: begin
        if (loadIndex == `CTD_FUSE_LAST) begin
          next_state = ctd_pkg::CTD_LOAD_DONE;
        end else begin
          next_loadIndex = loadIndex + 3'h1;
        end
      end
      default: begin
        next_state = ctd_pkg::CTD_LOAD_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ctd_pkg::CTD_LOAD_IDLE;
      loadIndex <= '0;
    end else begin
      state     <= next_state;
      loadIndex <= next_loadIndex;
    end
  end

  assign loadValid = (state == ctd_pkg::CTD_LOAD_RUN);
  assign loadDone  = (state == ctd_pkg::CTD_LOAD_DONE);

endmodule

// *** ctd_pkg.sv ***
/*
  types for the converter trim and dither register bank.
  assumes ctd_cfg.svh is available on the include path.
*/
`include "ctd_cfg.svh"

package ctd_pkg;

  // ----------------------------------------
  // dither control fields
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] reserved;
    logic       ditherRoundingPlacement;
    logic       ditherAmplitudeSelect;
    logic       ditherEnable;
  } ctd_dither_type;

  // ----------------------------------------
  // sample timing adjustments per bank
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] bankZeroTimePhase0;
    logic [7:0] bankZeroTimePhase90;
    logic [7:0] bankOneTimePhase0;
    logic [7:0] bankOneTimePhase90;
  } ctd_timing_type;

  typedef enum logic [1:0] {
    CTD_LOAD_IDLE,
    CTD_LOAD_RUN,
    CTD_LOAD_DONE
  } ctd_load_state_type;

endpackage

// *** ctd_trim_regs.sv ***
/*
  converter trim and dither register bank: termination trims, dither
  control and per-bank sample timing adjustments, loaded from fuses.
  assumes fuse inputs are stable levels on clk and a master that follows
  the plain strobe protocol (one-cycle strobes, never both at once).
*/
`timescale 1ns/1ps
`include "ctd_cfg.svh"

// How it works
// - trim register for first input at 7E
// - trim register for second input at 7F
// - fuse values loaded after reset, writable
// - dither enable bit 0, resets one
// - bit 1 selects small or large dither
// - bit 2 places dither rounding error
// - bank zero phase0 timing at 102
// - bank zero phase90 timing at 103
// - bank one phase0 timing at 112
// - bank one phase90 timing at 113
module ctd_trim_regs (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [`CTD_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [7:0]              regRdata,
  input  wire logic [7:0]              fuseTrimA,
  input  wire logic [7:0]              fuseTrimB,
  input  wire logic [7:0]              fuseDither,
  input  wire logic [7:0]              fuseB0Phase0,
  input  wire logic [7:0]              fuseB0Phase90,
  input  wire logic [7:0]              fuseB1Phase0,
  input  wire logic [7:0]              fuseB1Phase90,
  output logic      [7:0]              firstInputTermTrim,
  output logic      [7:0]              secondInputTermTrim,
  output logic                         ditherEnable,
  output logic                         ditherAmplitudeSelect,
  output logic                         ditherRoundingPlacement,
  output ctd_pkg::ctd_timing_type      bankTiming,
  output logic                         fuseLoadDone
);

  // ----------------------------------------
  // fuse sequencing
  // ----------------------------------------
  logic                        loadValid;
  logic [`CTD_FUSE_IDX_W-1:0]  loadIndex;
  logic                        loadDone;

  ctd_fuse_loader u_loader (
    .clk       (clk),
    .rstn      (rstn),
    .loadValid (loadValid),
    .loadIndex (loadIndex),
    .loadDone  (loadDone)
  );

  // ----------------------------------------
  // register storage, entry order matches fuse order
  // ----------------------------------------
  logic [7:0] regFile      [`CTD_NUM_FUSE];
  logic [7:0] next_regFile [`CTD_NUM_FUSE];
  logic [7:0] fuseVal      [`CTD_NUM_FUSE];
  logic [`CTD_ADDR_W-1:0] regOfs [`CTD_NUM_FUSE];
  logic [7:0] rstVal       [`CTD_NUM_FUSE];

  assign fuseVal[0] = fuseTrimA;
  assign fuseVal[1] = fuseTrimB;
  assign fuseVal[2] = fuseDither;
  assign fuseVal[3] = fuseB0Phase0;
  assign fuseVal[4] = fuseB0Phase90;
  assign fuseVal[5] = fuseB1Phase0;
  assign fuseVal[6] = fuseB1Phase90;

  assign regOfs[0] = `CTD_OFS_TRIM_A;
  assign regOfs[1] = `CTD_OFS_TRIM_B;
  assign regOfs[2] = `CTD_OFS_DITHER;
  assign regOfs[3] = `CTD_OFS_B0_PH0;
  assign regOfs[4] = `CTD_OFS_B0_PH90;
  assign regOfs[5] = `CTD_OFS_B1_PH0;
  assign regOfs[6] = `CTD_OFS_B1_PH90;

  // ----------------------------------------
  // per entry next value: host write beats the fuse load
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CTD_NUM_FUSE; gi++) begin : g_entry
      always_comb begin
        next_regFile[gi] = regFile[gi];
        if (regWrite && (regAddr == regOfs[gi])) begin
          next_regFile[gi] = regWdata;
        end else if (loadValid && (loadIndex == 3'(gi))) begin
          next_regFile[gi] = fuseVal[gi];
        end
      end
      // constant reset values, fuses arrive only after release
      if (gi == 2) begin : g_dith_rst
        assign rstVal[gi] = `CTD_RST_DITHER;
      end else begin : g_trim_rst
        assign rstVal[gi] = `CTD_RST_TRIM;
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          regFile[gi] <= (gi == 2) ? `CTD_RST_DITHER : `CTD_RST_TRIM;
        end else begin
          regFile[gi] <= next_regFile[gi];
        end
      end

      // per entry checks, written once for all seven registers
      a_entry_reset: assert property (@(posedge clk)
        $rose(rstn) |-> regFile[gi] == rstVal[gi])
        else $error("register entry left reset with a wrong value");

      a_entry_load: assert property (@(posedge clk) disable iff (!rstn)
        loadValid && loadIndex == 3'(gi) && !(regWrite && regAddr == regOfs[gi])
        |=> regFile[gi] == $past(fuseVal[gi]))
        else $error("fuse value not loaded into its register entry");

      a_entry_wins: assert property (@(posedge clk) disable iff (!rstn)
        regWrite && regAddr == regOfs[gi] |=> regFile[gi] == $past(regWdata))
        else $error("host write lost against the fuse load");

      a_entry_holds: assert property (@(posedge clk) disable iff (!rstn)
        !(regWrite && regAddr == regOfs[gi]) && !(loadValid && loadIndex == 3'(gi))
        |=> $stable(regFile[gi]))
        else $error("register entry changed without a write or load");

      a_entry_read: assert property (@(posedge clk) disable iff (!rstn)
        regRead && regAddr == regOfs[gi] |=> regRdata == $past(regFile[gi]))
        else $error("read data do not match the register entry");
    end
  endgenerate

  // ----------------------------------------
  // read path: data stand one cycle after the read strobe
  // ----------------------------------------
  logic [7:0] next_regRdata;
  logic       next_fuseLoadDone;

  always_comb begin
    next_regRdata = `CTD_READ_UNMAPPED;
    if (regRead) begin
      if (regAddr == `CTD_OFS_TRIM_A) begin
        next_regRdata = regFile[0];
      end else if (regAddr == `CTD_OFS_TRIM_B) begin
        next_regRdata = regFile[1];
      end else if (regAddr == `CTD_OFS_DITHER) begin
        next_regRdata = regFile[2];
      end else if (regAddr == `CTD_OFS_B0_PH0) begin
        next_regRdata = regFile[3];
      end else if (regAddr == `CTD_OFS_B0_PH90) begin
        next_regRdata = regFile[4];
      end else if (regAddr == `CTD_OFS_B1_PH0) begin
        next_regRdata = regFile[5];
      end else if (regAddr == `CTD_OFS_B1_PH90) begin
        next_regRdata = regFile[6];
      end
    end
    next_fuseLoadDone = loadDone;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata     <= `CTD_READ_UNMAPPED;
      fuseLoadDone <= 1'b0;
    end else begin
      regRdata     <= next_regRdata;
      fuseLoadDone <= next_fuseLoadDone;
    end
  end

  // ----------------------------------------
  // analog control outputs, straight from storage flops
  // ----------------------------------------
  ctd_pkg::ctd_dither_type dither;
  assign dither = ctd_pkg::ctd_dither_type'(regFile[2]);

  assign firstInputTermTrim      = regFile[0];
  assign secondInputTermTrim     = regFile[1];
  assign ditherEnable            = dither.ditherEnable;
  assign ditherAmplitudeSelect   = dither.ditherAmplitudeSelect;
  assign ditherRoundingPlacement = dither.ditherRoundingPlacement;
  // phase selection lives in the analog core; both sets are always presented
  assign bankTiming.bankZeroTimePhase0  = regFile[3];
  assign bankTiming.bankZeroTimePhase90 = regFile[4];
  assign bankTiming.bankOneTimePhase0   = regFile[5];
  assign bankTiming.bankOneTimePhase90  = regFile[6];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_trim_a_write: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_TRIM_A |=> firstInputTermTrim == $past(regWdata))
    else $error("first input trim did not take the write");

  a_trim_b_write: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_TRIM_B |=> secondInputTermTrim == $past(regWdata))
    else $error("second input trim did not take the write");

  a_fuse_load_a: assert property (@(posedge clk) disable iff (!rstn)
    loadValid && loadIndex == 3'h0 && !regWrite |=> firstInputTermTrim == $past(fuseTrimA))
    else $error("fuse value not loaded into first trim");

  a_dither_en_bit: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_DITHER |=> ditherEnable == $past(regWdata[0]))
    else $error("dither enable does not follow bit 0");

  a_dither_amp_bit: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_DITHER |=> ditherAmplitudeSelect == $past(regWdata[1]))
    else $error("dither amplitude does not follow bit 1");

  a_dither_err_bit: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_DITHER |=> ditherRoundingPlacement == $past(regWdata[2]))
    else $error("rounding placement does not follow bit 2");

  a_b0_phase0: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_B0_PH0 |=> bankTiming.bankZeroTimePhase0 == $past(regWdata))
    else $error("bank zero phase0 timing wrong");

  a_b0_phase90: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_B0_PH90 |=> bankTiming.bankZeroTimePhase90 == $past(regWdata))
    else $error("bank zero phase90 timing wrong");

  a_b1_phase0: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_B1_PH0 |=> bankTiming.bankOneTimePhase0 == $past(regWdata))
    else $error("bank one phase0 timing wrong");

  a_b1_phase90: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_B1_PH90 |=> bankTiming.bankOneTimePhase90 == $past(regWdata))
    else $error("bank one phase90 timing wrong");

  a_dither_readback: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_DITHER ##1 regRead && regAddr == `CTD_OFS_DITHER
    && !regWrite |=> regRdata == $past(regWdata, 2))
    else $error("dither register does not read back as written");

  a_trim_holds: assert property (@(posedge clk) disable iff (!rstn)
    loadDone && !(regWrite && regAddr == `CTD_OFS_TRIM_A) |=> $stable(firstInputTermTrim))
    else $error("first input trim changed without a write");

  a_trim_b_holds: assert property (@(posedge clk) disable iff (!rstn)
    loadDone && !(regWrite && regAddr == `CTD_OFS_TRIM_B) |=> $stable(secondInputTermTrim))
    else $error("second input trim changed without a write");

  a_timing_holds: assert property (@(posedge clk) disable iff (!rstn)
    loadDone && !regWrite |=> $stable(bankTiming))
    else $error("bank timing changed without a write");

  a_dither_holds: assert property (@(posedge clk) disable iff (!rstn)
    loadDone && !regWrite |=> $stable(dither))
    else $error("dither control changed without a write");

  a_dither_reserved: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && regAddr == `CTD_OFS_DITHER
    |=> dither.reserved == $past(regWdata[`CTD_DITH_RSV_HI:`CTD_DITH_RSV_LO]))
    else $error("reserved dither bits not stored as written");

  a_dither_on_reset: assert property (@(posedge clk)
    $rose(rstn) |-> ditherEnable)
    else $error("dither not enabled out of reset");

  a_small_on_reset: assert property (@(posedge clk)
    $rose(rstn) |-> !ditherAmplitudeSelect)
    else $error("dither amplitude not small out of reset");

  a_noise_on_reset: assert property (@(posedge clk)
    $rose(rstn) |-> !ditherRoundingPlacement)
    else $error("rounding placement not on noise out of reset");

  // ----------------------------------------
  // load and readback checks
  // ----------------------------------------
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !regRead |=> regRdata == `CTD_READ_UNMAPPED)
    else $error("read data stand outside the cycle after a read");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rstn)
    regRead && regAddr != `CTD_OFS_TRIM_A && regAddr != `CTD_OFS_TRIM_B
    && regAddr != `CTD_OFS_DITHER && regAddr != `CTD_OFS_B0_PH0
    && regAddr != `CTD_OFS_B0_PH90 && regAddr != `CTD_OFS_B1_PH0
    && regAddr != `CTD_OFS_B1_PH90
    |=> regRdata == `CTD_READ_UNMAPPED)
    else $error("unmapped read did not return zero");

  a_load_window: assert property (@(posedge clk) disable iff (!rstn)
    $rose(loadValid) |-> loadValid [*7] ##1 !loadValid)
    else $error("fuse load did not run for one cycle per entry");

  a_load_done_time: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> !fuseLoadDone ##8 !fuseLoadDone ##1 fuseLoadDone)
    else $error("load done status not raised on time");

  a_load_done_holds: assert property (@(posedge clk) disable iff (!rstn)
    fuseLoadDone |=> fuseLoadDone)
    else $error("load done status dropped before reset");

  a_load_index: assert property (@(posedge clk) disable iff (!rstn)
    loadValid |-> loadIndex <= `CTD_FUSE_LAST)
    else $error("fuse load index ran past the last entry");

endmodule

// *** ctd_trim_regs_tb.sv ***
/*
  self-checking bench for the converter trim and dither register bank.
  assumes ctd_cfg.svh and ctd_pkg are compiled first; the bench drives fuses.
*/
`timescale 1ns/1ps
`include "ctd_cfg.svh"

module ctd_trim_regs_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                     clk;
  logic                     rstn;
  logic [`CTD_ADDR_W-1:0]   regAddr;
  logic [7:0]               regWdata;
  logic                     regWrite;
  logic                     regRead;
  logic [7:0]               regRdata;
  logic [7:0]               fuseVal [7];
  logic [7:0]               expVal [7];
  logic [7:0]               wrVal [7];
  logic [11:0]              regOfs [7];
  logic [7:0]               firstInputTermTrim;
  logic [7:0]               secondInputTermTrim;
  logic                     ditherEnable;
  logic                     ditherAmplitudeSelect;
  logic                     ditherRoundingPlacement;
  ctd_pkg::ctd_timing_type  bankTiming;
  logic                     fuseLoadDone;
  int                       num_errors;
  int                       tests_run;
  int                       cycles;

  ctd_trim_regs uut (
    .clk                     (clk),
    .rstn                    (rstn),
    .regAddr                 (regAddr),
    .regWdata                (regWdata),
    .regWrite                (regWrite),
    .regRead                 (regRead),
    .regRdata                (regRdata),
    .fuseTrimA               (fuseVal[0]),
    .fuseTrimB               (fuseVal[1]),
    .fuseDither              (fuseVal[2]),
    .fuseB0Phase0            (fuseVal[3]),
    .fuseB0Phase90           (fuseVal[4]),
    .fuseB1Phase0            (fuseVal[5]),
    .fuseB1Phase90           (fuseVal[6]),
    .firstInputTermTrim      (firstInputTermTrim),
    .secondInputTermTrim     (secondInputTermTrim),
    .ditherEnable            (ditherEnable),
    .ditherAmplitudeSelect   (ditherAmplitudeSelect),
    .ditherRoundingPlacement (ditherRoundingPlacement),
    .bankTiming              (bankTiming),
    .fuseLoadDone            (fuseLoadDone)
  );

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  always #10 clk = ~clk;

  // whole run is under two hundred cycles; generous ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe stays up so writes can run back to back; idle() drops it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regRead  <= 1'b0;
    regAddr  <= a;
    regWdata <= d;
  endtask

  task automatic idle();
    @(posedge clk);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRead  <= 1'b1;
    regWrite <= 1'b0;
    regAddr  <= a;
    @(posedge clk);
    regRead  <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  function automatic logic [7:0] outVal(input int i);
    case (i)
      0: outVal = firstInputTermTrim;
      1: outVal = secondInputTermTrim;
      2: outVal = {5'h00, ditherRoundingPlacement, ditherAmplitudeSelect, ditherEnable};
      3: outVal = bankTiming.bankZeroTimePhase0;
      4: outVal = bankTiming.bankZeroTimePhase90;
      5: outVal = bankTiming.bankOneTimePhase0;
      default: outVal = bankTiming.bankOneTimePhase90;
    endcase
  endfunction

  // reserved dither bits have no output pin, only readback sees them
  task automatic checkAll();
    for (int i = 0; i < 7; i++) begin
      rd(regOfs[i], expVal[i]);
      chk(outVal(i), (i == 2) ? (expVal[i] & 8'h07) : expVal[i]);
    end
  endtask

  task automatic waitLoad();
    int n;
    n = 0;
    while (fuseLoadDone !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, fuseLoadDone}, 8'h01);
  endtask

  task automatic checkReset();
    for (int i = 0; i < 7; i++) begin
      chk(outVal(i), (i == 2) ? 8'h01 : 8'h00);
    end
    chk(regRdata, 8'h00);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    regAddr = '0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    regOfs = '{12'h07E, 12'h07F, 12'h09D, 12'h102, 12'h103, 12'h112, 12'h113};
    fuseVal = '{8'h3C, 8'hE1, 8'h06, 8'h9B, 8'h47, 8'hD2, 8'h18};
    wrVal = '{8'h5A, 8'hC3, 8'hFA, 8'h01, 8'h80, 8'hFF, 8'h7E};
    repeat (8) @(posedge clk);
    #1 checkReset();
    @(posedge clk) rstn <= 1'b1;
    waitLoad();
    expVal = fuseVal;
    checkAll();
    // back-to-back writes to every register, then readback
    for (int i = 0; i < 7; i++) wr(regOfs[i], wrVal[i]);
    idle();
    expVal = wrVal;
    checkAll();
    // every dither field combination, reserved bits at 5'h15
    for (int k = 0; k < 8; k++) begin
      wr(12'h09D, {5'h15, k[2:0]});
      idle();
      chk({7'h00, ditherEnable}, {7'h00, k[0]});
      chk({7'h00, ditherAmplitudeSelect}, {7'h00, k[1]});
      chk({7'h00, ditherRoundingPlacement}, {7'h00, k[2]});
      rd(12'h09D, {5'h15, k[2:0]});
    end
    expVal[2] = 8'hAF;
    // write then read with no gap between the strobes
    wr(12'h09D, 8'hAF);
    rd(12'h09D, 8'hAF);
    // unmapped neighbours and an upper-bit alias must stay inert
    wr(12'h07D, 8'hFF);
    wr(12'h09C, 8'hFF);
    wr(12'h104, 8'hFF);
    wr(12'h17E, 8'hFF);
    rd(12'h17E, 8'h00);
    rd(12'h114, 8'h00);
    @(posedge clk);
    #1 chk(regRdata, 8'h00);
    checkAll();
    // second reset mid-run with new fuse contents
    @(posedge clk) rstn <= 1'b0;
    fuseVal <= '{8'h81, 8'h24, 8'h07, 8'h66, 8'hA9, 8'h0F, 8'hF0};
    @(posedge clk);
    #1 checkReset();
    chk({7'h00, fuseLoadDone}, 8'h00);
    @(posedge clk) rstn <= 1'b1;
    waitLoad();
    expVal = fuseVal;
    checkAll();
    print_verdict();
  end
endmodule
